// ===== hdl/lhw_pkg.sv
// Package for the LCD host write decode and power control block
package lhw_pkg;

  localparam int unsigned BYTE_W = 8;
  localparam int unsigned NIB_W = 4;
  localparam int unsigned BITCNT_W = 3;
  localparam logic [BITCNT_W-1:0] BITCNT_LAST = 3'h7;
  localparam logic [BITCNT_W-1:0] BITCNT_INIT = 3'h0;
  localparam logic [BYTE_W-1:0] BYTE_ZERO = 8'h00;

  // Command opcode fields
  localparam logic [3:0] OP_PSAVE = 4'h4;
  localparam logic [3:0] OP_PCTL = 4'h5;
  localparam logic [3:0] OP_CONTRAST = 4'h7;
  localparam int unsigned OP_HI = 7;
  localparam int unsigned OP_LO = 4;
  localparam int unsigned PCTL_ZERO_BIT = 3;
  localparam int unsigned PCTL_REG_BIT = 2;
  localparam int unsigned PCTL_FOL_BIT = 1;
  localparam int unsigned PCTL_BST_BIT = 0;
  localparam int unsigned PSAVE_OSC_BIT = 1;
  localparam int unsigned PSAVE_SLP_BIT = 0;
  localparam logic [NIB_W-1:0] CONTRAST_RST = 4'h0;

  // Power stage settings
  typedef struct packed {
    logic regulator_enable_bit;
    logic follower_enable_bit;
    logic booster_en;
  } lhw_pwr_t;

  localparam lhw_pwr_t PWR_RST = '{1'b0, 1'b0, 1'b0};

  // One accepted host write
  typedef struct packed {
    logic valid;
    logic is_data;
    logic [BYTE_W-1:0] byte_val;
  } lhw_wr_t;

  localparam lhw_wr_t WR_RST = '{1'b0, 1'b0, 8'h00};

  typedef enum logic [1:0] {
    LHW_AWAKE,
    LHW_SLEEP
  } lhw_slp_state_t;

endpackage : lhw_pkg

// ===== hdl/lhw_serial_rx.sv
// Serial byte receiver with chip-select clear
`timescale 1ns/1ps
`default_nettype none
module lhw_serial_rx
  import lhw_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic cs_n_i,
  input wire logic si_i,
  input wire logic sck_i,
  input wire logic dcs_i,
  output lhw_wr_t wr_o
);

  logic sck_q_ff;
  logic sck_ok_ff;
  logic [BYTE_W-1:0] shift_ff;
  logic [BITCNT_W-1:0] cnt_ff;
  lhw_wr_t wr_ff;
  // The first sample after reset is no real clock edge
  wire sck_rise = sck_i & ~sck_q_ff & ~cs_n_i & sck_ok_ff;
  wire byte_done = sck_rise && (cnt_ff == BITCNT_LAST);
  wire [BYTE_W-1:0] shifted = {shift_ff[BYTE_W-2:0], si_i};

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      sck_q_ff <= 1'b0;
      sck_ok_ff <= 1'b0;
    end else begin
      sck_q_ff <= sck_i;
      sck_ok_ff <= 1'b1;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      shift_ff <= BYTE_ZERO;
      cnt_ff <= BITCNT_INIT;
    end else if (cs_n_i) begin
      shift_ff <= BYTE_ZERO;
      cnt_ff <= BITCNT_INIT;
    end else if (sck_rise) begin
      shift_ff <= shifted;
      cnt_ff <= cnt_ff + 3'h1;
    end
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      wr_ff <= WR_RST;
    end else begin
      wr_ff.valid <= byte_done;
      if (byte_done) begin
        wr_ff.is_data <= dcs_i;
        wr_ff.byte_val <= shifted;
      end
    end
  end

  assign wr_o = wr_ff;

  property p_cs_clears;
    @(posedge mclk_i) disable iff (!arst_n_i)
      cs_n_i |=> (cnt_ff == BITCNT_INIT);
  endproperty
  a_cs_clears: assert property (p_cs_clears) else $error("counter not cleared");

  property p_eight_bits;
    @(posedge mclk_i) disable iff (!arst_n_i)
      byte_done |=> wr_ff.valid && wr_ff.byte_val == $past(shifted);
  endproperty
  a_eight_bits: assert property (p_eight_bits) else $error("byte not delivered");

  property p_dcs_sampled;
    @(posedge mclk_i) disable iff (!arst_n_i)
      byte_done |=> wr_ff.is_data == $past(dcs_i);
  endproperty
  a_dcs_sampled: assert property (p_dcs_sampled) else $error("select not sampled");

  property p_no_byte_unselected;
    @(posedge mclk_i) disable iff (!arst_n_i)
      $past(cs_n_i) |-> !wr_ff.valid;
  endproperty
  a_no_byte_unselected: assert property (p_no_byte_unselected) else $error("byte while idle");

  c_serial_byte: cover property (@(posedge mclk_i) disable iff (!arst_n_i) wr_ff.valid);

endmodule : lhw_serial_rx
`default_nettype wire

// ===== hdl/lhw_host_write.sv
// Host write decode and LCD power control front end
// Notes on behaviour
// - select high write stores display data
// - select low write loads a command
// - accept transfers only while chip selected
// - unselected: ignore data, select, strobe, serial
// - deselect clears serial shifter and counter
// - hardware reset works regardless of select
// - three power stages enabled independently
// - four-bit contrast register, sixteen levels
// - contrast zero after reset or zero write
// - sleep only with stages and oscillator off
// - serial MSB first, byte on eighth edge
// - select sampled at byte-completing serial edge
// - power command low bits: regulator, follower, booster
// - power save low bits: oscillator, sleep
`timescale 1ns/1ps
`default_nettype none
module lhw_host_write
  import lhw_pkg::*;
(
  input wire logic mclk_i,
  input wire logic arst_n_i,
  input wire logic hardware_reset_in_i,
  input wire logic bus68_sel_i,
  input wire logic parallel_sel_i,
  input wire logic cs_n_i,
  input wire logic data_command_select_i,
  input wire logic strobe_i,
  input wire logic [7:0] data_i,
  output logic ram_wr_o,
  output logic [7:0] ram_data_o,
  output logic cmd_wr_o,
  output logic [7:0] cmd_data_o,
  output logic regulator_enable_bit_o,
  output logic follower_enable_bit_o,
  output logic booster_en_o,
  output logic osc_en_o,
  output logic sleep_request_bit_o,
  output logic sleep_o,
  output logic [3:0] contrast_o
);

  ////////////////////////////////////////////////////////////////////////
  // Reset and strobe edge

  logic strobe_q_ff;
  logic strobe_ok_ff;
  lhw_wr_t par_ff;
  lhw_wr_t ser_wr;
  lhw_wr_t cmd_ff;
  lhw_wr_t ram_ff;
  lhw_pwr_t pwr_ff;
  logic osc_ff;
  logic slp_req_ff;
  logic [NIB_W-1:0] contrast_ff;
  lhw_slp_state_t slp_ff;
  lhw_slp_state_t nxt_slp;
  logic sleep_ff;

  // Hardware reset acts while high, never looking at chip select
  wire soft_rst = hardware_reset_in_i;

  // 68 style takes the byte as enable falls; 80 style on the rising write
  wire strobe_end = bus68_sel_i ? (strobe_q_ff & ~strobe_i) : (~strobe_q_ff & strobe_i);
  // The first sample after reset is no real edge of either bus style
  wire par_take = parallel_sel_i && !cs_n_i && strobe_end && strobe_ok_ff;
  wire ser_cs_n = cs_n_i | parallel_sel_i;

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      strobe_q_ff <= 1'b0;
      strobe_ok_ff <= 1'b0;
    end else begin
      strobe_q_ff <= strobe_i;
      strobe_ok_ff <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Parallel and serial capture

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      par_ff <= WR_RST;
    end else begin
      par_ff.valid <= par_take;
      if (par_take) begin
        par_ff.is_data <= data_command_select_i;
        par_ff.byte_val <= data_i;
      end
    end
  end

  lhw_serial_rx u_serial_rx (
    .mclk_i(mclk_i),
    .arst_n_i(arst_n_i),
    .cs_n_i(ser_cs_n),
    .si_i(data_i[7]),
    .sck_i(data_i[6]),
    .dcs_i(data_command_select_i),
    .wr_o(ser_wr)
  );

  wire lhw_wr_t acc = parallel_sel_i ? par_ff : ser_wr;
  wire acc_data = acc.valid && acc.is_data;
  wire acc_cmd = acc.valid && !acc.is_data;
  wire [3:0] opcode = acc.byte_val[OP_HI:OP_LO];
  wire is_pctl = acc_cmd && opcode == OP_PCTL && !acc.byte_val[PCTL_ZERO_BIT];
  wire is_psave = acc_cmd && opcode == OP_PSAVE;
  wire is_contrast = acc_cmd && opcode == OP_CONTRAST;

  ////////////////////////////////////////////////////////////////////////
  // Write routing

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      ram_ff <= WR_RST;
      cmd_ff <= WR_RST;
    end else begin
      ram_ff.valid <= acc_data && !soft_rst;
      cmd_ff.valid <= acc_cmd && !soft_rst;
      if (acc_data) begin
        ram_ff.byte_val <= acc.byte_val;
      end
      if (acc_cmd) begin
        cmd_ff.byte_val <= acc.byte_val;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////
  // Power control, contrast and sleep

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      pwr_ff <= PWR_RST;
      osc_ff <= 1'b0;
      slp_req_ff <= 1'b0;
      contrast_ff <= CONTRAST_RST;
    end else if (soft_rst) begin
      pwr_ff <= PWR_RST;
      osc_ff <= 1'b0;
      slp_req_ff <= 1'b0;
      contrast_ff <= CONTRAST_RST;
    end else begin
      if (is_pctl) begin
        pwr_ff.regulator_enable_bit <= acc.byte_val[PCTL_REG_BIT];
        pwr_ff.follower_enable_bit <= acc.byte_val[PCTL_FOL_BIT];
        pwr_ff.booster_en <= acc.byte_val[PCTL_BST_BIT];
      end
      if (is_psave) begin
        osc_ff <= acc.byte_val[PSAVE_OSC_BIT];
        slp_req_ff <= acc.byte_val[PSAVE_SLP_BIT];
      end
      if (is_contrast) begin
        contrast_ff <= acc.byte_val[NIB_W-1:0];
      end
    end
  end

  // Sleep needs stages and oscillator already off; a request with them
  // running is held pending and honoured once they are switched off
  wire all_off = (pwr_ff == PWR_RST) && !osc_ff;

  // A command that starts a stage or the oscillator leaves sleep in the
  // same edge that the stage turns on, so sleep never overlaps a live stage
  wire wake_pctl = is_pctl && |acc.byte_val[PCTL_REG_BIT:PCTL_BST_BIT];
  wire wake_psave = is_psave && (acc.byte_val[PSAVE_OSC_BIT] || !acc.byte_val[PSAVE_SLP_BIT]);
  wire wake_cmd = wake_pctl || wake_psave;

  always_comb begin
    nxt_slp = slp_ff;
    case (slp_ff)
      LHW_AWAKE: if (slp_req_ff && all_off && !wake_cmd) nxt_slp = LHW_SLEEP;
      LHW_SLEEP: if (!slp_req_ff || !all_off || wake_cmd) nxt_slp = LHW_AWAKE;
      default: nxt_slp = LHW_AWAKE;
    endcase
  end

  always_ff @(posedge mclk_i or negedge arst_n_i) begin
    if (!arst_n_i) begin
      slp_ff <= LHW_AWAKE;
      sleep_ff <= 1'b0;
    end else if (soft_rst) begin
      slp_ff <= LHW_AWAKE;
      sleep_ff <= 1'b0;
    end else begin
      slp_ff <= nxt_slp;
      sleep_ff <= (nxt_slp == LHW_SLEEP);
    end
  end

  assign ram_wr_o = ram_ff.valid;
  assign ram_data_o = ram_ff.byte_val;
  assign cmd_wr_o = cmd_ff.valid;
  assign cmd_data_o = cmd_ff.byte_val;
  assign regulator_enable_bit_o = pwr_ff.regulator_enable_bit;
  assign follower_enable_bit_o = pwr_ff.follower_enable_bit;
  assign booster_en_o = pwr_ff.booster_en;
  assign osc_en_o = osc_ff;
  assign sleep_request_bit_o = slp_req_ff;
  assign sleep_o = sleep_ff;
  assign contrast_o = contrast_ff;

  ////////////////////////////////////////////////////////////////////////
  // Checks

  property p_ram_from_data;
    @(posedge mclk_i) disable iff (!arst_n_i)
      ram_ff.valid |-> $past(acc.valid && acc.is_data);
  endproperty
  a_ram_from_data: assert property (p_ram_from_data) else $error("ram write without data");

  property p_cmd_from_cmd;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (acc_cmd && !soft_rst) |=> cmd_ff.valid && cmd_ff.byte_val == $past(acc.byte_val);
  endproperty
  a_cmd_from_cmd: assert property (p_cmd_from_cmd) else $error("command lost");

  property p_par_needs_cs;
    @(posedge mclk_i) disable iff (!arst_n_i)
      par_ff.valid |-> $past(!cs_n_i);
  endproperty
  a_par_needs_cs: assert property (p_par_needs_cs) else $error("write while deselected");

  property p_reset_clears;
    @(posedge mclk_i) disable iff (!arst_n_i)
      hardware_reset_in_i |=> contrast_ff == CONTRAST_RST && pwr_ff == PWR_RST && !osc_ff;
  endproperty
  a_reset_clears: assert property (p_reset_clears) else $error("reset ignored");

  property p_pctl_load;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (is_pctl && !soft_rst) |=> pwr_ff == $past(acc.byte_val[2:0]);
  endproperty
  a_pctl_load: assert property (p_pctl_load) else $error("power bits wrong");

  property p_contrast_load;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (is_contrast && !soft_rst) |=> contrast_ff == $past(acc.byte_val[3:0]);
  endproperty
  a_contrast_load: assert property (p_contrast_load) else $error("contrast wrong");

  property p_contrast_zero;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (is_contrast && !soft_rst && acc.byte_val[3:0] == CONTRAST_RST) ##1 !is_contrast
        |=> contrast_ff == CONTRAST_RST || $past(soft_rst);
  endproperty
  a_contrast_zero: assert property (p_contrast_zero) else $error("contrast not zero");

  property p_sleep_all_off;
    @(posedge mclk_i) disable iff (!arst_n_i)
      sleep_o |-> !osc_ff && pwr_ff == PWR_RST && slp_req_ff;
  endproperty
  a_sleep_all_off: assert property (p_sleep_all_off) else $error("sleep with stages on");

  property p_psave_bits;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (is_psave && !soft_rst) |=> osc_ff == $past(acc.byte_val[1]) && slp_req_ff == $past(acc.byte_val[0]);
  endproperty
  a_psave_bits: assert property (p_psave_bits) else $error("power save bits wrong");

  property p_wake_leaves;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (wake_cmd && !soft_rst) |=> !sleep_o;
  endproperty
  a_wake_leaves: assert property (p_wake_leaves) else $error("sleep kept on wake");

  property p_pctl_ignored;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (acc_cmd && opcode == OP_PCTL && acc.byte_val[PCTL_ZERO_BIT] && !soft_rst)
        |=> $stable(pwr_ff);
  endproperty
  a_pctl_ignored: assert property (p_pctl_ignored) else $error("bad power command used");

  property p_data_no_ctl;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (acc_data && !soft_rst) |=> $stable(pwr_ff) && $stable(osc_ff) && $stable(contrast_ff);
  endproperty
  a_data_no_ctl: assert property (p_data_no_ctl) else $error("data write moved controls");

  property p_ram_load;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (acc_data && !soft_rst) |=> ram_ff.valid && ram_ff.byte_val == $past(acc.byte_val);
  endproperty
  a_ram_load: assert property (p_ram_load) else $error("display byte lost");

  property p_reset_no_pulse;
    @(posedge mclk_i) disable iff (!arst_n_i)
      soft_rst |=> !ram_ff.valid && !cmd_ff.valid;
  endproperty
  a_reset_no_pulse: assert property (p_reset_no_pulse) else $error("write during reset");

  property p_contrast_hold;
    @(posedge mclk_i) disable iff (!arst_n_i)
      (!is_contrast && !soft_rst) |=> $stable(contrast_ff);
  endproperty
  a_contrast_hold: assert property (p_contrast_hold) else $error("contrast drifted");

  c_ram_write: cover property (@(posedge mclk_i) disable iff (!arst_n_i) ram_ff.valid);
  c_cmd_write: cover property (@(posedge mclk_i) disable iff (!arst_n_i) cmd_ff.valid);
  c_sleep: cover property (@(posedge mclk_i) disable iff (!arst_n_i) sleep_o);
  c_booster_only_off: cover property (@(posedge mclk_i) disable iff (!arst_n_i)
    pwr_ff.regulator_enable_bit && !pwr_ff.booster_en);

endmodule : lhw_host_write
`default_nettype wire

// ===== verification/lhw_host_model.sv
// Host processor model that drives parallel and serial writes
`timescale 1ns/1ps
`default_nettype none
module lhw_host_model (
  input wire logic mclk_i,
  output logic cs_n_o,
  output logic dcs_o,
  output logic strobe_o,
  output logic [7:0] data_o,
  output logic bus68_o,
  output logic par_o
);
  initial begin
    cs_n_o = 1'b1;
    dcs_o = 1'b0;
    strobe_o = 1'b1;
    data_o = 8'h00;
    bus68_o = 1'b0;
    par_o = 1'b1;
  end

  task automatic step(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : step

  // Released data lines and dcs_o show the inverse of their last value, never a stale copy; cs_n_o goes high
  task automatic release_bus();
    cs_n_o = 1'b1;
    dcs_o = ~dcs_o;
    data_o = ~data_o;
  endtask : release_bus

  ////////////////////////////////////////////////////////////////////////////
  task automatic par_wr(input logic m68, input logic cs_n, input logic dcs,
                        input logic [7:0] b);
    step(1);
    bus68_o = m68;
    par_o = 1'b1;
    strobe_o = ~m68;
    step(2);
    cs_n_o = cs_n;
    dcs_o = dcs;
    data_o = b;
    step(1);
    strobe_o = m68;
    step(2);
    strobe_o = ~m68;
    step(2);
    release_bus();
  endtask : par_wr

  // Select is wrong until the last bit, so only the completing edge may decide
  task automatic ser_wr(input logic cs_n, input logic dcs, input logic [7:0] b, input int nbits);
    step(1);
    par_o = 1'b0;
    data_o = 8'h00;
    step(2);
    cs_n_o = cs_n;
    dcs_o = ~dcs;
    for (int i = 7; i > 7 - nbits; i--) begin
      data_o = {b[i], 7'h00};
      if (i == 0) dcs_o = dcs;
      step(2);
      data_o[6] = 1'b1;
      step(2);
    end
    data_o[6] = 1'b0;
    step(2);
    release_bus();
  endtask : ser_wr
endmodule : lhw_host_model
`default_nettype wire

// ===== verification/lhw_host_write_tb.sv
// Self-checking bench for the host write decode and power control block
`timescale 1ns/1ps
`default_nettype none
module lhw_host_write_tb;
  import lhw_pkg::*;
  typedef struct packed {
    logic [3:0] mode;
    logic [3:0] dcs;
    logic [7:0] b;
    logic [3:0] pwr;
    logic [3:0] flg;
    logic [3:0] con;
  } lhw_row_t;
  logic mclk_i = 1'b0;
  logic arst_n_i = 1'b0;
  logic hw_rst = 1'b0;
  wire logic cs_n, dcs, strobe, bus68, par;
  wire logic [7:0] data, ram_data, cmd_data;
  wire logic ram_wr, cmd_wr, reg_en, fol_en, bst_en, osc_en, slp_req, slp;
  wire logic [3:0] con;
  int fails = 0;
  int total_checks = 0;
  int n_ram = 0;
  int n_cmd = 0;
  int e_ram = 0;
  int e_cmd = 0;
  // Mode 0 is 80 style, 1 is 68 style, 2 is serial; flags are osc, request, sleep
  lhw_row_t rows [16] = '{
    28'h01A5000, 28'h113C000, 28'h2181000,
    28'h0042040,
    28'h1057740, 28'h2056640, 28'h0052240,
    28'h105C240,
    28'h0041220, 28'h2050030, 28'h1043060,
    28'h0078068, 28'h2077067,
    28'h107F06F, 28'h0070060, 28'h0040000};

  always #4 mclk_i = ~mclk_i;

  always @(posedge mclk_i) begin
    if (ram_wr === 1'b1) n_ram++;
    if (cmd_wr === 1'b1) n_cmd++;
  end

  lhw_host_model lhw_host_model_i (.mclk_i(mclk_i), .cs_n_o(cs_n), .dcs_o(dcs),
    .strobe_o(strobe), .data_o(data), .bus68_o(bus68), .par_o(par));

  lhw_host_write lhw_host_write_i (.mclk_i(mclk_i), .arst_n_i(arst_n_i),
    .hardware_reset_in_i(hw_rst), .bus68_sel_i(bus68), .parallel_sel_i(par),
    .cs_n_i(cs_n), .data_command_select_i(dcs), .strobe_i(strobe), .data_i(data),
    .ram_wr_o(ram_wr), .ram_data_o(ram_data), .cmd_wr_o(cmd_wr), .cmd_data_o(cmd_data),
    .regulator_enable_bit_o(reg_en), .follower_enable_bit_o(fol_en),
    .booster_en_o(bst_en), .osc_en_o(osc_en), .sleep_request_bit_o(slp_req),
    .sleep_o(slp), .contrast_o(con));

  ////////////////////////////////////////////////////////////////////////////
  task automatic chk_v(input logic [7:0] got, input logic [7:0] exp);
    total_checks++;
    if (got !== exp) begin
      fails++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_v

  task automatic chk_n(input int got, input int exp);
    total_checks++;
    if (got != exp) begin
      fails++;
      $display("Error t=%0t got %h exp %h", $time, got, exp);
    end
  endtask : chk_n

  task automatic wait_n(input int n);
    repeat (n) @(posedge mclk_i);
    #1;
  endtask : wait_n

  task automatic chk_state(input lhw_row_t r);
    chk_v({5'h00, reg_en, fol_en, bst_en}, {4'h0, r.pwr});
    chk_v({5'h00, osc_en, slp_req, slp}, {4'h0, r.flg});
    chk_v({4'h0, con}, {4'h0, r.con});
    chk_n(n_ram, e_ram);
    chk_n(n_cmd, e_cmd);
  endtask : chk_state

  task automatic do_wr(input logic [3:0] m, input logic cs_n, input logic d, input logic [7:0] b);
    if (m == 4'h2) lhw_host_model_i.ser_wr(cs_n, d, b, 8);
    else lhw_host_model_i.par_wr(m[0], cs_n, d, b);
  endtask : do_wr

  task automatic wr_row(input lhw_row_t r);
    do_wr(r.mode, 1'b0, r.dcs[0], r.b);
    wait_n(5);
    if (r.dcs[0]) begin
      e_ram++;
      chk_v(ram_data, r.b);
    end else begin
      e_cmd++;
      chk_v(cmd_data, r.b);
    end
    chk_state(r);
  endtask : wr_row

  task automatic summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask : summarize

  ////////////////////////////////////////////////////////////////////////////
  initial begin
    wait_n(2);
    chk_v({ram_wr, cmd_wr, reg_en, fol_en, bst_en, osc_en, slp_req, slp}, 8'h00);
    chk_v({con, 4'h0}, 8'h00);
    wait_n(1);
    arst_n_i = 1'b1;
    wait_n(2);
    chk_state(28'h0);
    $display("reset test done");
    for (int k = 0; k < 16; k++) begin
      wr_row(rows[k]);
    end
    $display("table test done");
    // Every transfer below runs with the chip unselected and must leave no trace
    do_wr(4'h0, 1'b1, 1'b0, 8'h57);
    do_wr(4'h1, 1'b1, 1'b1, 8'h11);
    do_wr(4'h2, 1'b1, 1'b0, 8'h7F);
    wait_n(5);
    chk_state(28'h0);
    $display("deselect test done");
    // A broken serial byte of ones would corrupt the next byte if not discarded
    lhw_host_model_i.ser_wr(1'b0, 1'b1, 8'hFF, 5);
    wr_row(28'h21C3000);
    $display("partial byte test done");
    wr_row(28'h0042040);
    wr_row(28'h1057740);
    wr_row(28'h007F74F);
    hw_rst = 1'b1;
    wait_n(2);
    chk_state(28'h0);
    do_wr(4'h1, 1'b0, 1'b0, 8'h43);
    hw_rst = 1'b0;
    wait_n(5);
    chk_state(28'h0);
    $display("hardware reset test done");
    summarize();
  end
endmodule : lhw_host_write_tb
`default_nettype wire
